// ==== bpd_block_peak_detector.sv ====
// Block peak power detector with four hysteresis thresholds and dwell.
// Assumes one sample per clock from the converter stream, and a byte-wide
// register port whose master never issues read and write together.
//
// What this block does
// R1: Detector runs only while enable bit set.
// R2: Block length is unsigned linear 17-bit count.
// R3: Length counts peaks of 8 converter samples.
// R4: Length bytes at 001h, 002h, bit16 003h.
// R5: Software: decimate 4/6 length multiple 5xD.
// R6: Software: decimate 8-32 length multiple 10xD.
// R7: Four 8-bit thresholds, 256 equals full scale.
// R8: Flag sets when peak exceeds set threshold.
// R9: Flag clears after dwell below clear threshold.
// R10: Block peak is max reduced sample, restart.

`include "bpd_defines.svh"

module bpd_block_peak_detector (
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    // Register port
    input  wire logic [`BPD_ADDR_W-1:0]   reg_addr,
    input  wire logic [`BPD_DATA_W-1:0]   reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [`BPD_DATA_W-1:0]   reg_rdata,
    // Converter sample stream
    input  wire bpd_pkg::bpd_sample_s     sample_in,
    // Detector outputs
    output bpd_pkg::bpd_flags_s           flags_out,
    output logic                          block_done,
    output logic                          irq
);
    import bpd_pkg::*;

    // ======================================================================
    // Helpers

    // Magnitude scaled so that negative full scale reads exactly 256
    function automatic bpd_mag_t sample_mag(input logic signed [`BPD_SAMPLE_W-1:0] s);
        logic [`BPD_SAMPLE_W-1:0] a;
        a = s[`BPD_SAMPLE_W-1] ? (~s + 1'b1) : s;
        if (s[`BPD_SAMPLE_W-1] && (a == {1'b1, {(`BPD_SAMPLE_W-1){1'b0}}})) begin
            return bpd_mag_t'(a >> `BPD_MAG_SHIFT);
        end
        return bpd_mag_t'(a[`BPD_SAMPLE_W-2:0] >> `BPD_MAG_SHIFT);
    endfunction

    function automatic bpd_mag_t mag_max(input bpd_mag_t a, input bpd_mag_t b);
        return (a > b) ? a : b;
    endfunction

    // ======================================================================
    // Configuration registers

    logic [`BPD_DATA_W-1:0]   enable_reg;
    logic [`BPD_DATA_W-1:0]   len_low;
    logic [`BPD_DATA_W-1:0]   len_mid;
    logic [`BPD_DATA_W-1:0]   len_top;
    logic [`BPD_DATA_W-1:0]   hi_set_th;
    logic [`BPD_DATA_W-1:0]   hi_clr_th;
    logic [`BPD_DATA_W-1:0]   lo_set_th;
    logic [`BPD_DATA_W-1:0]   lo_clr_th;
    logic [`BPD_DATA_W-1:0]   dwell_low;
    logic [`BPD_DATA_W-1:0]   dwell_high;
    logic [`BPD_IRQ_W-1:0]    irq_mask;
    logic [`BPD_IRQ_W-1:0]    irq_status;

    logic                     det_en;
    logic [`BPD_LEN_W-1:0]    block_length;
    logic [`BPD_LEN_W-1:0]    length_eff;
    logic [`BPD_DWELL_W-1:0]  dwell;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            enable_reg <= `BPD_REG_RESET;
            len_low    <= `BPD_REG_RESET;
            len_mid    <= `BPD_REG_RESET;
            len_top    <= `BPD_REG_RESET;
            hi_set_th  <= `BPD_REG_RESET;
            hi_clr_th  <= `BPD_REG_RESET;
            lo_set_th  <= `BPD_REG_RESET;
            lo_clr_th  <= `BPD_REG_RESET;
            dwell_low  <= `BPD_REG_RESET;
            dwell_high <= `BPD_REG_RESET;
            irq_mask   <= `BPD_IRQ_W'(`BPD_REG_RESET);
        end else if (reg_wr) begin
            unique case (reg_addr)
                // Unused bits are kept at zero so they read back as zero
                `BPD_OFF_ENABLE: begin
                    enable_reg <= {{(`BPD_DATA_W-1){1'b0}}, reg_wdata[`BPD_ENABLE_BIT]};
                end
                `BPD_OFF_LEN_LOW:    len_low    <= reg_wdata; // [R4]
                `BPD_OFF_LEN_MID:    len_mid    <= reg_wdata; // [R4]
                `BPD_OFF_LEN_TOP: begin
                    len_top <= {{(`BPD_DATA_W-1){1'b0}}, reg_wdata[`BPD_LEN_TOP_BIT]}; // [R4]
                end
                `BPD_OFF_HI_SET:     hi_set_th  <= reg_wdata; // [R7]
                `BPD_OFF_HI_CLR:     hi_clr_th  <= reg_wdata; // [R7]
                `BPD_OFF_LO_SET:     lo_set_th  <= reg_wdata; // [R7]
                `BPD_OFF_LO_CLR:     lo_clr_th  <= reg_wdata; // [R7]
                `BPD_OFF_DWELL_LOW:  dwell_low  <= reg_wdata;
                `BPD_OFF_DWELL_HIGH: dwell_high <= reg_wdata;
                `BPD_OFF_IRQ_MASK:   irq_mask   <= reg_wdata[`BPD_IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    assign det_en       = enable_reg[`BPD_ENABLE_BIT];                          // [R1]
    assign block_length = {len_top[`BPD_LEN_TOP_BIT], len_mid, len_low};        // [R2] [R4]
    // A zero length would close a block on every reduced sample; it behaves as a length of one
    assign length_eff   = (block_length == '0) ? `BPD_LEN_W'(1) : block_length;
    assign dwell        = {dwell_high, dwell_low};

    // ======================================================================
    // Reduction: one value per group of 8 converter samples

    logic [`BPD_GROUP_W-1:0]  group_cnt;
    bpd_mag_t                 group_max;
    bpd_mag_t                 cur_mag;
    logic                     red_valid;
    bpd_mag_t                 red_value;

    assign cur_mag = sample_mag(sample_in.data);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            group_cnt <= '0;
            group_max <= '0;
            red_valid <= 1'b0;
            red_value <= '0;
        end else if (!det_en) begin                                             // [R1]
            group_cnt <= '0;
            group_max <= '0;
            red_valid <= 1'b0;
        end else begin
            red_valid <= 1'b0;
            if (sample_in.valid) begin
                if (group_cnt == `BPD_GROUP_LAST) begin                         // [R3]
                    red_value <= mag_max(group_max, cur_mag);
                    red_valid <= 1'b1;
                    group_max <= '0;
                end else begin
                    group_max <= mag_max(group_max, cur_mag);
                end
                group_cnt <= group_cnt + 1'b1;
            end
        end
    end

    // ======================================================================
    // Block accumulation over the programmed number of reduced samples

    logic [`BPD_LEN_W-1:0]    blk_cnt;
    bpd_mag_t                 blk_max;
    bpd_mag_t                 block_peak;
    bpd_mag_t                 blk_next_max;

    assign blk_next_max = mag_max(blk_max, red_value);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            blk_cnt    <= '0;
            blk_max    <= '0;
            block_peak <= '0;
            block_done <= 1'b0;
        end else if (!det_en) begin                                             // [R1]
            blk_cnt    <= '0;
            blk_max    <= '0;
            block_done <= 1'b0;
        end else begin
            block_done <= 1'b0;
            if (red_valid) begin
                if (blk_cnt + 1'b1 >= length_eff) begin                         // [R2] [R3]
                    block_peak <= blk_next_max;                                 // [R10]
                    block_done <= 1'b1;
                    blk_cnt    <= '0;                                           // [R10]
                    blk_max    <= '0;
                end else begin
                    blk_cnt    <= blk_cnt + 1'b1;
                    blk_max    <= blk_next_max;
                end
            end
        end
    end

    // ======================================================================
    // Hysteresis comparators with dwell

    // Dwell time ticks once per reduced sample, i.e. at sample rate over 8
    logic [`BPD_DWELL_W-1:0]  hi_dwell_cnt;
    logic [`BPD_DWELL_W-1:0]  lo_dwell_cnt;
    logic                     hi_below;
    logic                     lo_below;
    logic                     hi_flag;
    logic                     lo_flag;
    logic                     hi_rise;
    logic                     lo_rise;

    // Thresholds are zero-extended, so a peak of 256 exceeds every setting
    assign hi_below = block_peak < bpd_mag_t'(hi_clr_th);
    assign lo_below = block_peak < bpd_mag_t'(lo_clr_th);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hi_flag      <= 1'b0;
            hi_dwell_cnt <= '0;
        end else if (!det_en) begin                                             // [R1]
            hi_flag      <= 1'b0;
            hi_dwell_cnt <= '0;
        end else if (block_done && (block_peak > bpd_mag_t'(hi_set_th))) begin
            hi_flag      <= 1'b1;                                               // [R8]
            hi_dwell_cnt <= '0;
        end else if (hi_flag && hi_below) begin
            if (hi_dwell_cnt >= dwell) begin
                hi_flag      <= 1'b0;                                           // [R9]
                hi_dwell_cnt <= '0;
            end else if (red_valid) begin
                hi_dwell_cnt <= hi_dwell_cnt + 1'b1;                            // [R9]
            end
        end else begin
            // Any peak at or above the clear level restarts the dwell
            hi_dwell_cnt <= '0;                                                 // [R9]
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            lo_flag      <= 1'b0;
            lo_dwell_cnt <= '0;
        end else if (!det_en) begin                                             // [R1]
            lo_flag      <= 1'b0;
            lo_dwell_cnt <= '0;
        end else if (block_done && (block_peak > bpd_mag_t'(lo_set_th))) begin
            lo_flag      <= 1'b1;                                               // [R8]
            lo_dwell_cnt <= '0;
        end else if (lo_flag && lo_below) begin
            if (lo_dwell_cnt >= dwell) begin
                lo_flag      <= 1'b0;                                           // [R9]
                lo_dwell_cnt <= '0;
            end else if (red_valid) begin
                lo_dwell_cnt <= lo_dwell_cnt + 1'b1;                            // [R9]
            end
        end else begin
            lo_dwell_cnt <= '0;                                                 // [R9]
        end
    end

    // Edge detectors for the two flag-rise interrupt events
    logic                     hi_flag_d;
    logic                     lo_flag_d;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hi_flag_d <= 1'b0;
            lo_flag_d <= 1'b0;
        end else begin
            hi_flag_d <= hi_flag;
            lo_flag_d <= lo_flag;
        end
    end

    assign hi_rise = hi_flag & ~hi_flag_d;
    assign lo_rise = lo_flag & ~lo_flag_d;

    assign flags_out = '{high_flag: hi_flag, low_flag: lo_flag};

    // ======================================================================
    // Interrupt status, cleared by reading it

    logic [`BPD_IRQ_W-1:0]    irq_events;
    logic [`BPD_IRQ_W-1:0]    irq_clear;

    always_comb begin
        irq_events                    = '0;
        irq_events[`BPD_IRQ_HI_RISE]  = hi_rise;
        irq_events[`BPD_IRQ_LO_RISE]  = lo_rise;
        irq_events[`BPD_IRQ_BLOCK]    = block_done;
    end

    assign irq_clear = (reg_rd && (reg_addr == `BPD_OFF_IRQ_STATUS)) ? '1 : '0;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_status <= '0;
        end else begin
            // A new event in the clearing cycle survives the read
            irq_status <= (irq_status & ~irq_clear) | irq_events;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ======================================================================
    // Read port: data stand in the cycle after the strobe only

    logic [`BPD_DATA_W-1:0]   next_rdata;
    logic [`BPD_DATA_W-1:0]   peak_byte;

    // Full-scale 256 does not fit a byte; it reads back saturated
    assign peak_byte = (block_peak > `BPD_PEAK_SAT) ? '1 : block_peak[`BPD_DATA_W-1:0];

    always_comb begin
        next_rdata = '0;
        unique case (reg_addr)
            `BPD_OFF_ENABLE:     next_rdata = enable_reg;
            `BPD_OFF_LEN_LOW:    next_rdata = len_low;
            `BPD_OFF_LEN_MID:    next_rdata = len_mid;
            `BPD_OFF_LEN_TOP:    next_rdata = len_top;
            `BPD_OFF_HI_SET:     next_rdata = hi_set_th;
            `BPD_OFF_HI_CLR:     next_rdata = hi_clr_th;
            `BPD_OFF_LO_SET:     next_rdata = lo_set_th;
            `BPD_OFF_LO_CLR:     next_rdata = lo_clr_th;
            `BPD_OFF_DWELL_LOW:  next_rdata = dwell_low;
            `BPD_OFF_DWELL_HIGH: next_rdata = dwell_high;
            `BPD_OFF_IRQ_STATUS: next_rdata = `BPD_DATA_W'(irq_status);
            `BPD_OFF_IRQ_MASK:   next_rdata = `BPD_DATA_W'(irq_mask);
            `BPD_OFF_FLAGS:      next_rdata = `BPD_DATA_W'({lo_flag, hi_flag});
            `BPD_OFF_PEAK:       next_rdata = peak_byte;
            default:             next_rdata = '0;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule

// ==== bpd_defines.svh ====
// Register offsets, field positions, reset values and widths of the peak detector.
// Assumes inclusion by bare name from the package and the detector module.
`ifndef BPD_DEFINES_SVH
`define BPD_DEFINES_SVH

// ==========================================================================
// Register offsets
`define BPD_ADDR_W           8
`define BPD_DATA_W           8
`define BPD_OFF_ENABLE       8'h00
`define BPD_OFF_LEN_LOW      8'h01
`define BPD_OFF_LEN_MID      8'h02
`define BPD_OFF_LEN_TOP      8'h03
`define BPD_OFF_HI_SET       8'h07
`define BPD_OFF_HI_CLR       8'h08
`define BPD_OFF_LO_SET       8'h09
`define BPD_OFF_LO_CLR       8'h0a
`define BPD_OFF_DWELL_LOW    8'h0b
`define BPD_OFF_DWELL_HIGH   8'h0c
`define BPD_OFF_IRQ_STATUS   8'h20
`define BPD_OFF_IRQ_MASK     8'h21
`define BPD_OFF_FLAGS        8'h22
`define BPD_OFF_PEAK         8'h23

// ==========================================================================
// Fields and reset values
`define BPD_ENABLE_BIT       0
`define BPD_LEN_TOP_BIT      0
`define BPD_LEN_W            17
`define BPD_DWELL_W          16
`define BPD_REG_RESET        8'h00
`define BPD_IRQ_W            3
`define BPD_IRQ_HI_RISE      0
`define BPD_IRQ_LO_RISE      1
`define BPD_IRQ_BLOCK        2

// ==========================================================================
// Sample path
`define BPD_SAMPLE_W         14
`define BPD_MAG_W            9
`define BPD_MAG_SHIFT        5
`define BPD_GROUP_W          3
`define BPD_GROUP_LAST       3'h7
`define BPD_PEAK_SAT         9'h0ff

`endif

// ==== bpd_pkg.sv ====
// Types shared by the block peak power detector and its surroundings.
// Assumes bpd_defines.svh is on the include path.
`include "bpd_defines.svh"

package bpd_pkg;

    // One converter sample per clock when valid is high
    typedef struct packed {
        logic                             valid;
        logic signed [`BPD_SAMPLE_W-1:0]  data;
    } bpd_sample_s;

    // Hysteresis detector flags towards the gain-control loop
    typedef struct packed {
        logic high_flag;
        logic low_flag;
    } bpd_flags_s;

    typedef logic [`BPD_MAG_W-1:0] bpd_mag_t;

endpackage

// ==== bpd_assertions.sv ====
// Port checks for the block peak power detector.
// Assumes a bind to bpd_block_peak_detector; registers shadowed from bus writes.
module bpd_assertions (
    // Clock and reset
    input wire logic                 clock,
    input wire logic                 sys_rst,
    // Register port
    input wire logic [7:0]           reg_addr,
    input wire logic [7:0]           reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_rdata,
    // Stream and outputs
    input wire bpd_pkg::bpd_sample_s sample_in,
    input wire bpd_pkg::bpd_flags_s  flags_out,
    input wire logic                 block_done,
    input wire logic                 irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import bpd_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    logic [7:0]  shadow [16];
    logic [16:0] len_raw;
    int          len_q, dwell_q, nsmp, nblk, hs;
    assign len_raw = {shadow[3][0], shadow[2], shadow[1]};
    assign len_q = (len_raw == 17'h00000) ? 1 : int'(len_raw);
    assign dwell_q = int'({shadow[12], shadow[11]});
    // ======================================================================
    // Register shadow, 0x00 and 0x03 keep bit 0 only
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            shadow <= '{default: 8'h00};
        end else if (reg_wr && reg_addr < 8'h10) begin
            shadow[reg_addr[3:0]] <= (reg_addr == 8'h00 || reg_addr == 8'h03) ?
                                     {7'h00, reg_wdata[0]} : reg_wdata;
        end
    end
    // ======================================================================
    // Sample and block counters; cleared with enable since partial blocks are dropped, hs cleared with the high flag
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            nsmp <= 0;
            nblk <= 0;
            hs   <= 0;
        end else begin
            nsmp <= !shadow[0][0] ? 0 : nsmp + int'(sample_in.valid);
            nblk <= !shadow[0][0] ? 0 : nblk + int'(block_done);
            hs   <= !flags_out.high_flag ? 0 : hs + int'(sample_in.valid);
        end
    end
    // ======================================================================
    // Properties
    property p_rd_shadow;
        reg_rd && (reg_addr < 8'h04 || reg_addr inside {[8'h07:8'h0c]})
            |=> reg_rdata == $past(shadow[reg_addr[3:0]]);
    endproperty
    a_rd_shadow: assert property (p_rd_shadow) else $error("read data not last write");
    property p_rd_zero;
        !reg_rd || reg_addr inside {[8'h04:8'h06], [8'h0d:8'h1f]} |=> reg_rdata == 8'h00;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");
    property p_disabled; !shadow[0][0] [*3] |=> !block_done && flags_out == 2'b00; endproperty
    a_disabled: assert property (p_disabled) else $error("detector active while off");
    property p_blk_samples; block_done |-> nsmp >= 8 * len_q * (nblk + 1); endproperty
    a_blk_samples: assert property (p_blk_samples) else $error("block too early");
    property p_done_pulse; block_done |=> !block_done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("block done too long");
    property p_hi_rise; $rose(flags_out.high_flag) |-> $past(block_done); endproperty
    a_hi_rise: assert property (p_hi_rise) else $error("high flag rose off block");
    property p_lo_rise; $rose(flags_out.low_flag) |-> $past(block_done); endproperty
    a_lo_rise: assert property (p_lo_rise) else $error("low flag rose off block");
    property p_hi_dwell; $fell(flags_out.high_flag) && shadow[0][0] |-> hs >= 8 * (dwell_q - 1);
    endproperty
    a_hi_dwell: assert property (p_hi_dwell) else $error("high flag cleared early");
endmodule

// ==== bpd_sample_source.sv ====
// Converter sample stream model feeding the peak detector.
// Assumes the bench pulses go for one cycle beside level, count and slow.
module bpd_sample_source (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    // Commands from the bench
    input  wire logic signed [13:0]   level,
    input  wire logic [15:0]          count,
    input  wire logic                 go,
    input  wire logic                 slow,
    // Stream towards the detector
    output bpd_pkg::bpd_sample_s      sample_out,
    output logic                      busy
);
    timeunit 1ns;
    timeprecision 1ns;
    import bpd_pkg::*;
    logic [15:0] left;
    logic        pace;
    // ======================================================================
    // Pacing; idle data toggles so a stale word never passes for a sample
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            left       <= 16'h0000;
            pace       <= 1'b0;
            sample_out <= '0;
        end else if (go) begin
            left             <= count;
            sample_out.valid <= 1'b0;
        end else if (left != 16'h0000 && (!slow || pace)) begin
            left       <= left - 16'h0001;
            pace       <= 1'b0;
            sample_out <= '{valid: 1'b1, data: level};
        end else begin
            pace             <= 1'b1;
            sample_out.valid <= 1'b0;
            sample_out.data  <= ~sample_out.data;
        end
    end
    assign busy = (left != 16'h0000);
endmodule

// ==== bpd_block_peak_detector_tb_top.sv ====
// Self-checking bench for the block peak power detector.
// Assumes the stream model and the checker are compiled before it.
`define CHK(n, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("BAD %s exp %0h got %0h", n, e, g); \
    end \
end

module bpd_block_peak_detector_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 clock, sys_rst, reg_wr, reg_rd, go, slow, block_done, irq, busy;
    logic [7:0]           reg_addr, reg_wdata, reg_rdata;
    logic signed [13:0]   level;
    logic [15:0]          count;
    bpd_pkg::bpd_sample_s sample_in;
    bpd_pkg::bpd_flags_s  flags_out;
    int                   miscompares, checks_done, ndone, cycles;
    logic [7:0]           offs [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h08, 8'h09,
                                        8'h0a, 8'h0b, 8'h0c, 8'h20, 8'h21, 8'h05};
    bpd_block_peak_detector DUT (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sample_in(sample_in), .flags_out(flags_out), .block_done(block_done), .irq(irq));
    bpd_sample_source u_src (.clock(clock), .sys_rst(sys_rst), .level(level), .count(count),
        .go(go), .slow(slow), .sample_out(sample_in), .busy(busy));
    // ======================================================================
    // Clock, block counter and hang guard
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        ndone += int'(block_done === 1'b1);
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            print_verdict();
        end
    end
    // ======================================================================
    // Bus and stream tasks
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        `CHK($sformatf("reg %0h", a), e, reg_rdata)
    endtask
    // Waits out the pipeline so flags and status have landed
    task automatic send(input logic [13:0] v, input logic [15:0] n, input logic s);
        int k;
        @(posedge clock);
        level <= v;
        count <= n;
        slow  <= s;
        go    <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        k = 0;
        @(negedge clock);
        while (busy !== 1'b0 && k < 5000) begin
            @(negedge clock);
            k++;
        end
        if (k >= 5000) miscompares++;
        repeat (6) @(negedge clock);
    endtask
    // ======================================================================
    // Tests
    initial begin
        sys_rst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd, go, slow, level, count} = '0;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        foreach (offs[i]) rd(offs[i], 8'h00);
        wr(8'h03, 8'hff);
        rd(8'h03, 8'h01);
        wr(8'h00, 8'hfe);
        rd(8'h00, 8'h00);
        for (int i = 7; i < 13; i++) wr(8'(i), 8'(8'hc0 + i));
        for (int i = 7; i < 13; i++) rd(8'(i), 8'(8'hc0 + i));
        wr(8'h03, 8'h00);
        $display("test register access done");
        send(14'h0400, 16'h0010, 1'b0);
        `CHK("blocks", 0, ndone)
        rd(8'h23, 8'h00);
        $display("test disabled done");
        wr(8'h01, 8'h01); // No decimation, any length legal
        wr(8'h02, 8'h01);
        wr(8'h00, 8'h01);
        send(14'h0040, 16'h0800, 1'b0);
        `CHK("blocks", 0, ndone)
        send(14'h0040, 16'h0008, 1'b1);
        `CHK("blocks", 1, ndone)
        rd(8'h23, 8'h02);
        $display("test block length done");
        wr(8'h00, 8'h00);
        wr(8'h02, 8'h00);
        wr(8'h07, 8'h10);
        wr(8'h08, 8'h08);
        wr(8'h09, 8'h08);
        wr(8'h0a, 8'h04);
        wr(8'h0b, 8'h02);
        wr(8'h0c, 8'h00);
        wr(8'h00, 8'h01);
        send(14'h0200, 16'h0008, 1'b0);
        `CHK("flags", 2'b01, flags_out)
        `CHK("irq", 1'b0, irq)
        send(14'h0220, 16'h0008, 1'b0);
        `CHK("flags", 2'b11, flags_out)
        rd(8'h22, 8'h03);
        wr(8'h21, 8'h07);
        @(negedge clock);
        `CHK("irq", 1'b1, irq)
        rd(8'h20, 8'h07);
        `CHK("irq", 1'b0, irq)
        $display("test thresholds done");
        send(14'h00a0, 16'h0008, 1'b0);
        `CHK("flags", 2'b11, flags_out)
        send(14'h00a0, 16'h0018, 1'b0);
        `CHK("flags", 2'b01, flags_out)
        rd(8'h23, 8'h05);
        wr(8'h00, 8'h00);
        repeat (2) @(negedge clock);
        `CHK("flags", 2'b00, flags_out)
        $display("test dwell done");
        wr(8'h01, 8'h02);
        wr(8'h00, 8'h01);
        send(14'h2000, 16'h0008, 1'b0);
        send(14'h0020, 16'h0008, 1'b0);
        `CHK("blocks", 8, ndone)
        rd(8'h23, 8'hff);
        `CHK("flags", 2'b11, flags_out)
        $display("test full scale done");
        print_verdict();
    end
endmodule

bind bpd_block_peak_detector bpd_assertions u_chk (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_in(sample_in), .flags_out(flags_out),
    .block_done(block_done), .irq(irq));
